// ==== src/cbcs_bus_sequencer.sv ====
// Machine-cycle sequencer: states, bus strobes, wait, hold, halt, interrupt and reset
`include "cbcs_consts.svh"
module cbcs_bus_sequencer #(
  parameter int STATE_CLKS = `CBCS_STATE_CLKS,
  parameter logic [7:0] RESTART_CODE = `CBCS_RESTART_CODE
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_reset_request_in_n,
  input wire logic i_ready_request_in,
  input wire logic i_interrupt_request,
  input wire logic i_hold_request,
  input wire logic i_bus_output_enable_n,
  input wire logic i_interrupt_enable_flag,
  input wire logic i_req_valid,
  input wire cbcs_pkg::cbcs_kind_t i_req_kind,
  input wire logic [15:0] i_req_addr,
  input wire logic [7:0] i_req_wdata,
  input wire logic [2:0] i_req_states,
  input wire logic i_req_last,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  output logic [7:0] o_low_address_byte,
  output logic [7:0] o_high_address_byte,
  output logic o_address_oe_n,
  output logic o_sync,
  output logic o_status_strobe_n,
  output logic o_memory_read_strobe_n,
  output logic o_memory_write_strobe_n,
  output logic o_port_read_strobe_n,
  output logic o_early_port_write_strobe_n,
  output logic o_write_strobe_n,
  output logic o_strobe_oe_n,
  output logic o_hold_acknowledge,
  output logic o_halted,
  output logic o_req_accept,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic [15:0] o_pc
);
  import cbcs_pkg::*;

  localparam cbcs_seq_t SEQ_RST = '{
    st: CBCS_S_IDLE,
    ret: CBCS_S_IDLE,
    kind: CBCS_K_FETCH,
    nst: `CBCS_MIN_STATES,
    pc: `CBCS_PC_RESET,
    mrd_n: 1'b1,
    mwr_n: 1'b1,
    prd_n: 1'b1,
    epw_n: 1'b1,
    wr_n: 1'b1,
    strobe_oe_n: 1'b1,
    data_oe_n: 1'b1,
    addr_oe_n: 1'b1,
    default: '0
  };

  cbcs_tim_if tim ();

  cbcs_timebase #(
    .STATE_CLKS(STATE_CLKS)
  ) u_timebase (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ready_request_in(i_ready_request_in),
    .i_interrupt_request(i_interrupt_request),
    .i_hold_request(i_hold_request),
    .i_reset_request_in_n(i_reset_request_in_n),
    .tim(tim)
  );

  cbcs_seq_t q;
  cbcs_seq_t next_q;
  logic fin;
  logic bnd;
  logic wcyc;
  logic rcyc;

  function automatic logic is_port(cbcs_kind_t k);
    return (k == CBCS_K_PORTIN) || (k == CBCS_K_PORTOUT);
  endfunction

  function automatic logic [7:0] status_of(cbcs_kind_t k, logic sub);
    logic [7:0] s;
    s = 8'h00;
    s[`CBCS_ST_INTA] = (k == CBCS_K_INTACK);
    s[`CBCS_ST_WO_N] = !((k == CBCS_K_MEMWR) || (k == CBCS_K_PORTOUT && sub));
    s[`CBCS_ST_HLTA] = (k == CBCS_K_HALT);
    s[`CBCS_ST_OUT] = (k == CBCS_K_PORTOUT) && sub;
    s[`CBCS_ST_M1] = (k == CBCS_K_FETCH) || (k == CBCS_K_INTACK);
    s[`CBCS_ST_INP] = (k == CBCS_K_PORTIN) && sub;
    s[`CBCS_ST_MEMORY_READ_STROBE_N] = (k == CBCS_K_FETCH) || (k == CBCS_K_MEMRD) ||
                       (k == CBCS_K_HALT) || (is_port(k) && !sub);
    return s;
  endfunction

  // Opens T1: sync high, status on the data bus
  function automatic cbcs_seq_t begin_cycle(cbcs_seq_t s, cbcs_kind_t k, logic sub,
                                            logic [15:0] tgt, logic [2:0] nst,
                                            logic last, logic [7:0] wd);
    cbcs_seq_t r;
    r = s;
    r.st = CBCS_S_T1;
    r.kind = k;
    r.sub = sub;
    r.tgt = tgt;
    // Requests shorter or longer than the legal range are clamped
    if (nst < `CBCS_MIN_STATES) begin
      r.nst = `CBCS_MIN_STATES;
    end else if (nst > `CBCS_MAX_STATES) begin
      r.nst = `CBCS_MAX_STATES;
    end else begin
      r.nst = nst;
    end
    r.last = last;
    r.wdata = wd;
    r.sync = 1'b1;
    r.drv = 1'b1;
    r.dout = status_of(k, sub);
    r.halted = 1'b0;
    r.hold_acknowledge = 1'b0;
    r.addr_oe_n = 1'b0;
    return r;
  endfunction

  always_comb begin
    next_q = q;
    fin = (q.st == CBCS_S_T3 && q.nst == `CBCS_MIN_STATES) ||
          (q.st == CBCS_S_T4 && q.nst == `CBCS_MID_STATES) ||
          (q.st == CBCS_S_T5);
    bnd = tim.ph1 && (q.st == CBCS_S_IDLE || fin);
    wcyc = (q.kind == CBCS_K_MEMWR) || (q.kind == CBCS_K_PORTOUT && q.sub);
    rcyc = (q.kind == CBCS_K_FETCH) || (q.kind == CBCS_K_MEMRD) ||
           (is_port(q.kind) && !q.sub);
    next_q.accept = 1'b0;
    next_q.done = 1'b0;
    if (tim.reset_req) begin
      next_q = SEQ_RST;
      next_q.stb_n = 1'b0;
    end else begin
      // Strobe held low by a reset request is let go once the request clears,
      // otherwise the first T1 after reset would show no falling strobe
      if (q.st == CBCS_S_IDLE) begin
        next_q.stb_n = 1'b1;
      end
      if (tim.ph2) begin
        if (q.st == CBCS_S_T1) begin
          next_q.addr = q.tgt;
          next_q.stb_n = 1'b0;
        end
        // Write strobe lingers into the state after T3
        if (!q.wr_n && q.st != CBCS_S_WAIT_STATE && q.st != CBCS_S_T3) begin
          next_q.wr_n = 1'b1;
          next_q.mwr_n = 1'b1;
        end
        if (fin && q.last && tim.intr && i_interrupt_enable_flag) begin
          next_q.int_latch = 1'b1;
        end
      end
      if (tim.ph1) begin
        case (q.st)
          CBCS_S_T1: begin
            next_q.st = CBCS_S_T2;
            next_q.sync = 1'b0;
            next_q.stb_n = 1'b1;
            next_q.drv = 1'b0;
            if (rcyc) begin
              next_q.mrd_n = 1'b0;
            end
            if (q.kind == CBCS_K_PORTIN && q.sub) begin
              next_q.prd_n = 1'b0;
            end
            if (q.kind == CBCS_K_PORTOUT && q.sub) begin
              next_q.epw_n = 1'b0;
            end
          end
          CBCS_S_T2: begin
            if (q.kind == CBCS_K_HALT) begin
              next_q.st = CBCS_S_HALT;
              next_q.halted = 1'b1;
            end else begin
              if (wcyc) begin
                next_q.drv = 1'b1;
                next_q.dout = q.wdata;
                next_q.wr_n = 1'b0;
              end
              if (q.kind == CBCS_K_MEMWR) begin
                next_q.mwr_n = 1'b0;
              end
              next_q.st = tim.ready ? CBCS_S_T3 : CBCS_S_WAIT_STATE;
            end
          end
          CBCS_S_WAIT_STATE: begin
            next_q.st = tim.ready ? CBCS_S_T3 : CBCS_S_WAIT_STATE;
          end
          CBCS_S_T3: begin
            next_q.mrd_n = 1'b1;
            next_q.prd_n = 1'b1;
            next_q.epw_n = 1'b1;
            next_q.done = 1'b1;
            // Controller blocks the bus and supplies the restart code
            next_q.rdata = (q.kind == CBCS_K_INTACK) ? RESTART_CODE : i_data;
            if (rcyc && q.kind != CBCS_K_MEMRD) begin
              next_q.pc = q.pc + 16'h0001;
            end
            if (is_port(q.kind) && !q.sub) begin
              next_q.port = i_data;
              next_q.io_pend = 1'b1;
            end
            if (q.kind == CBCS_K_INTACK) begin
              next_q.branch = 1'b1;
            end
            // Counter kept until the restart sequence is complete so it can be saved
            if (q.last && q.branch) begin
              next_q.pc = `CBCS_RESTART_VECTOR;
              next_q.branch = 1'b0;
            end
            next_q.st = (q.nst > `CBCS_MIN_STATES) ? CBCS_S_T4 : CBCS_S_IDLE;
          end
          CBCS_S_T4: begin
            next_q.st = (q.nst > `CBCS_MID_STATES) ? CBCS_S_T5 : CBCS_S_IDLE;
          end
          CBCS_S_T5: begin
            next_q.st = CBCS_S_IDLE;
          end
          CBCS_S_HALT: begin
            if (tim.hold) begin
              next_q.st = CBCS_S_HOLD;
              next_q.ret = CBCS_S_HALT;
              next_q.hold_acknowledge = 1'b1;
              // Hold is a state of its own, so the halt flag drops meanwhile
              next_q.halted = 1'b0;
              next_q.addr_oe_n = 1'b1;
            end else if (tim.intr && i_interrupt_enable_flag) begin
              next_q = begin_cycle(next_q, CBCS_K_INTACK, 1'b0, q.pc,
                                   `CBCS_MIN_STATES, 1'b0, 8'h00);
            end
          end
          CBCS_S_HOLD: begin
            if (!tim.hold) begin
              next_q.st = q.ret;
              next_q.hold_acknowledge = 1'b0;
              next_q.halted = (q.ret == CBCS_S_HALT);
              next_q.addr_oe_n = 1'b0;
            end
          end
          CBCS_S_IDLE: begin
            next_q.st = CBCS_S_IDLE;
          end
          default: begin
            next_q.st = CBCS_S_IDLE;
          end
        endcase
      end
      // Outside halt, hold is granted only between machine cycles
      if (bnd) begin
        next_q.drv = 1'b0;
        if (tim.hold) begin
          next_q.st = CBCS_S_HOLD;
          next_q.ret = CBCS_S_IDLE;
          next_q.hold_acknowledge = 1'b1;
          next_q.addr_oe_n = 1'b1;
        end else if (next_q.io_pend) begin
          next_q = begin_cycle(next_q, q.kind, 1'b1, {next_q.port, next_q.port},
                               `CBCS_MIN_STATES, 1'b1, next_q.wdata);
          next_q.io_pend = 1'b0;
        end else if (i_req_valid) begin
          next_q.accept = 1'b1;
          if (i_req_kind == CBCS_K_FETCH && q.int_latch) begin
            next_q = begin_cycle(next_q, CBCS_K_INTACK, 1'b0, next_q.pc,
                                 i_req_states, 1'b0, 8'h00);
            next_q.int_latch = 1'b0;
          end else begin
            next_q = begin_cycle(next_q, i_req_kind, 1'b0,
                                 (i_req_kind == CBCS_K_MEMRD ||
                                  i_req_kind == CBCS_K_MEMWR) ? i_req_addr : next_q.pc,
                                 is_port(i_req_kind) ? `CBCS_MIN_STATES : i_req_states,
                                 is_port(i_req_kind) ? 1'b0 : i_req_last,
                                 i_req_wdata);
          end
        end
      end
    end
    next_q.strobe_oe_n = i_bus_output_enable_n;
    next_q.data_oe_n = !next_q.drv || i_bus_output_enable_n;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= SEQ_RST;
    end else begin
      q <= next_q;
    end
  end

  assign o_data = q.dout;
  assign o_data_oe_n = q.data_oe_n;
  assign o_low_address_byte = q.addr[7:0];
  assign o_high_address_byte = q.addr[15:8];
  assign o_address_oe_n = q.addr_oe_n;
  assign o_sync = q.sync;
  assign o_status_strobe_n = q.stb_n;
  assign o_memory_read_strobe_n = q.mrd_n;
  assign o_memory_write_strobe_n = q.mwr_n;
  assign o_port_read_strobe_n = q.prd_n;
  assign o_early_port_write_strobe_n = q.epw_n;
  assign o_write_strobe_n = q.wr_n;
  assign o_strobe_oe_n = q.strobe_oe_n;
  assign o_hold_acknowledge = q.hold_acknowledge;
  assign o_halted = q.halted;
  assign o_req_accept = q.accept;
  assign o_done = q.done;
  assign o_rdata = q.rdata;
  assign o_pc = q.pc;
endmodule

// ==== include/cbcs_consts.svh ====
// Timing counts, reset values and status layout of the bus cycle sequencer
`ifndef CBCS_CONSTS_SVH
`define CBCS_CONSTS_SVH

`define CBCS_CLK_NS 8
`define CBCS_STATE_NS 488
`define CBCS_STATE_CLKS (`CBCS_STATE_NS / `CBCS_CLK_NS)

`define CBCS_PC_RESET 16'h0000
`define CBCS_RESTART_VECTOR 16'h0038
`define CBCS_RESTART_CODE 8'hFF
`define CBCS_MIN_STATES 3'h3
`define CBCS_MID_STATES 3'h4
`define CBCS_MAX_STATES 3'h5

`define CBCS_ST_INTA 0
`define CBCS_ST_WO_N 1
`define CBCS_ST_STACK 2
`define CBCS_ST_HLTA 3
`define CBCS_ST_OUT 4
`define CBCS_ST_M1 5
`define CBCS_ST_INP 6
`define CBCS_ST_MEMORY_READ_STROBE_N 7

`endif

// ==== include/cbcs_pkg.sv ====
// Types shared by the bus cycle sequencer and its timebase
package cbcs_pkg;

  typedef enum logic [3:0] {
    CBCS_S_IDLE,
    CBCS_S_T1,
    CBCS_S_T2,
    CBCS_S_WAIT_STATE,
    CBCS_S_T3,
    CBCS_S_T4,
    CBCS_S_T5,
    CBCS_S_HALT,
    CBCS_S_HOLD
  } cbcs_state_t;

  typedef enum logic [2:0] {
    CBCS_K_FETCH,
    CBCS_K_MEMRD,
    CBCS_K_MEMWR,
    CBCS_K_PORTIN,
    CBCS_K_PORTOUT,
    CBCS_K_HALT,
    CBCS_K_INTACK
  } cbcs_kind_t;

  typedef struct packed {
    cbcs_state_t st;
    cbcs_state_t ret;
    cbcs_kind_t kind;
    logic sub;
    logic io_pend;
    logic [2:0] nst;
    logic last;
    logic [15:0] pc;
    logic [15:0] tgt;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] port;
    logic [7:0] rdata;
    logic [7:0] dout;
    logic int_latch;
    logic branch;
    logic drv;
    logic sync;
    logic stb_n;
    logic mrd_n;
    logic mwr_n;
    logic prd_n;
    logic epw_n;
    logic wr_n;
    logic strobe_oe_n;
    logic data_oe_n;
    logic addr_oe_n;
    logic hold_acknowledge;
    logic halted;
    logic accept;
    logic done;
  } cbcs_seq_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic rdy_m;
    logic rdy;
    logic int_m;
    logic intr;
    logic hold_m;
    logic hold;
    logic rst_m;
    logic rst_n;
    logic ph1;
    logic ph2;
  } cbcs_tb_t;

endpackage

// ==== include/cbcs_tim_if.sv ====
// Phase enables and synchronised requests from timebase to sequencer
interface cbcs_tim_if;
  logic ph1;
  logic ph2;
  logic ready;
  logic intr;
  logic hold;
  logic reset_req;
  modport src (output ph1, ph2, ready, intr, hold, reset_req);
  modport snk (input ph1, ph2, ready, intr, hold, reset_req);
endinterface

// ==== src/cbcs_timebase.sv ====
// Two-phase enable generator and input synchronisers
`include "cbcs_consts.svh"
module cbcs_timebase #(
  parameter int STATE_CLKS = `CBCS_STATE_CLKS
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ready_request_in,
  input wire logic i_interrupt_request,
  input wire logic i_hold_request,
  input wire logic i_reset_request_in_n,
  cbcs_tim_if.src tim
);
  import cbcs_pkg::*;

  cbcs_tb_t q;
  cbcs_tb_t next_q;

  // Phase one at the state boundary, phase two half a state later
  always_comb begin
    next_q = q;
    next_q.cnt = (q.cnt == 8'(STATE_CLKS - 1)) ? 8'h00 : q.cnt + 8'h01;
    next_q.ph1 = (q.cnt == 8'(STATE_CLKS - 1));
    next_q.ph2 = (q.cnt == 8'(STATE_CLKS / 2 - 1));
    next_q.rdy_m = i_ready_request_in;
    next_q.rdy = q.rdy_m;
    next_q.int_m = i_interrupt_request;
    next_q.intr = q.int_m;
    next_q.hold_m = i_hold_request;
    next_q.hold = q.hold_m;
    next_q.rst_m = i_reset_request_in_n;
    next_q.rst_n = q.rst_m;
  end

  // Reset request reads active after power-up until the pin is seen high
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tim.ph1 = q.ph1;
  assign tim.ph2 = q.ph2;
  assign tim.ready = q.rdy;
  assign tim.intr = q.intr;
  assign tim.hold = q.hold;
  assign tim.reset_req = !q.rst_n;
endmodule

// ==== sim/cbcs_seq_properties.sv ====
// Port-level timing checks for the bus cycle sequencer
module cbcs_seq_checker (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_reset_request_in_n,
  input wire logic i_bus_output_enable_n,
  input wire logic [7:0] o_data,
  input wire logic o_data_oe_n,
  input wire logic [7:0] o_low_address_byte,
  input wire logic [7:0] o_high_address_byte,
  input wire logic o_address_oe_n,
  input wire logic o_sync,
  input wire logic o_status_strobe_n,
  input wire logic o_memory_read_strobe_n,
  input wire logic o_memory_write_strobe_n,
  input wire logic o_port_read_strobe_n,
  input wire logic o_early_port_write_strobe_n,
  input wire logic o_write_strobe_n,
  input wire logic o_strobe_oe_n,
  input wire logic o_hold_acknowledge,
  input wire logic o_halted,
  input wire logic o_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic wr_open;
  // Write strobe outlives its cycle, so data is only held until the cycle ends
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_open <= 1'b0;
    end else if (o_done || o_write_strobe_n) begin
      wr_open <= 1'b0;
    end else if ($fell(o_write_strobe_n)) begin
      wr_open <= 1'b1;
    end
  end
  mem_read_start_a: assert property ($fell(o_memory_read_strobe_n) |-> $fell(o_sync))
    else $error("memory read strobe not opened at T2");
  port_read_start_a: assert property ($fell(o_port_read_strobe_n) |-> $fell(o_sync))
    else $error("port read strobe not opened at T2");
  early_write_start_a: assert property ($fell(o_early_port_write_strobe_n) |-> $fell(o_sync))
    else $error("early port write strobe not opened at T2");
  port_addr_dup_a: assert property (!o_port_read_strobe_n |->
    o_low_address_byte == o_high_address_byte)
    else $error("port number not on both address bytes");
  write_data_hold_a: assert property (wr_open && !o_write_strobe_n && !o_done |->
    $stable(o_data) && !o_data_oe_n)
    else $error("write data moved while write strobe low");
  read_addr_hold_a: assert property (!o_memory_read_strobe_n && !$past(o_memory_read_strobe_n) |->
    $stable({o_high_address_byte, o_low_address_byte}))
    else $error("address moved during read");
  mem_write_window_a: assert property ($changed(o_memory_write_strobe_n) |->
    $changed(o_write_strobe_n))
    else $error("memory write strobe outside write window");
  hold_float_a: assert property (o_hold_acknowledge |-> o_address_oe_n && o_data_oe_n)
    else $error("buses driven during hold");
  reset_strobe_a: assert property (!i_reset_request_in_n [*4] |-> !o_status_strobe_n)
    else $error("status strobe released during reset request");
  bus_float_a: assert property (i_bus_output_enable_n [*3] |-> o_strobe_oe_n && o_data_oe_n)
    else $error("buffers driven with bus enable high");
  status_strobe_a: assert property ($rose(o_sync) |-> ##[1:40] $fell(o_status_strobe_n))
    else $error("no status strobe in T1");
  halt_quiet_a: assert property (o_halted |-> o_memory_read_strobe_n && o_port_read_strobe_n)
    else $error("read strobe active in halt");
endmodule

bind cbcs_bus_sequencer cbcs_seq_checker u_chk (.i_clk, .i_arst_n, .i_reset_request_in_n,
  .i_bus_output_enable_n, .o_data, .o_data_oe_n, .o_low_address_byte, .o_high_address_byte,
  .o_address_oe_n, .o_sync, .o_status_strobe_n, .o_memory_read_strobe_n,
  .o_memory_write_strobe_n, .o_port_read_strobe_n, .o_early_port_write_strobe_n,
  .o_write_strobe_n, .o_strobe_oe_n, .o_hold_acknowledge, .o_halted, .o_done);

// ==== sim/cbcs_bus_model.sv ====
// Memory and port responder on the system bus
module cbcs_bus_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_wait_clks,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_lo,
  input wire logic [7:0] i_hi,
  output logic [7:0] o_data,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  // Ready withheld for a set number of clocks after a strobe opens
  assign o_ready = (i_rd_n && i_wr_n) || (cnt >= i_wait_clks);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= 8'h00;
      o_data <= 8'h00;
    end else begin
      if (i_rd_n && i_wr_n) begin
        cnt <= 8'h00;
      end else if (cnt != 8'hFF) begin
        cnt <= cnt + 8'h01;
      end
      // Released bus toggles so a stale byte never looks valid
      if (!i_rd_n) begin
        o_data <= i_lo ^ i_hi ^ 8'hA5;
      end else begin
        o_data <= ~o_data;
      end
    end
  end
endmodule

// ==== sim/cpu_bus_cycle_sequencer_tb.sv ====
// Self-checking bench for the bus cycle sequencer
module cpu_bus_cycle_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cbcs_pkg::*;
  logic i_clk, i_arst_n, i_reset_request_in_n, i_ready_request_in, i_interrupt_request;
  logic i_hold_request, i_bus_output_enable_n, i_interrupt_enable_flag, i_req_valid, i_req_last;
  cbcs_kind_t i_req_kind;
  logic [15:0] i_req_addr, o_pc, io_addr;
  logic [7:0] i_req_wdata, i_data, o_data, o_low_address_byte, o_high_address_byte, o_rdata;
  logic [7:0] wait_clks, wr_data;
  logic [2:0] i_req_states;
  logic o_data_oe_n, o_address_oe_n, o_sync, o_status_strobe_n, o_memory_read_strobe_n;
  logic o_memory_write_strobe_n, o_port_read_strobe_n, o_early_port_write_strobe_n;
  logic o_write_strobe_n, o_strobe_oe_n, o_hold_acknowledge, o_halted, o_req_accept, o_done;
  int err_total, checks_done, cyc, rd_cnt, prd_cnt, epw_cnt, wr_cnt, mw_cnt;

  cbcs_bus_sequencer #(.STATE_CLKS(4)) u_dut (.i_clk, .i_arst_n, .i_reset_request_in_n,
    .i_ready_request_in, .i_interrupt_request, .i_hold_request, .i_bus_output_enable_n,
    .i_interrupt_enable_flag, .i_req_valid, .i_req_kind, .i_req_addr, .i_req_wdata,
    .i_req_states, .i_req_last, .i_data, .o_data, .o_data_oe_n, .o_low_address_byte,
    .o_high_address_byte, .o_address_oe_n, .o_sync, .o_status_strobe_n,
    .o_memory_read_strobe_n, .o_memory_write_strobe_n, .o_port_read_strobe_n,
    .o_early_port_write_strobe_n, .o_write_strobe_n, .o_strobe_oe_n, .o_hold_acknowledge,
    .o_halted, .o_req_accept, .o_done, .o_rdata, .o_pc);

  cbcs_bus_model u_mem (.i_clk, .i_arst_n, .i_wait_clks(wait_clks),
    .i_rd_n(o_memory_read_strobe_n & o_port_read_strobe_n),
    .i_wr_n(o_memory_write_strobe_n & o_early_port_write_strobe_n),
    .i_lo(o_low_address_byte), .i_hi(o_high_address_byte), .o_data(i_data),
    .o_ready(i_ready_request_in));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // Strobe widths and bus values seen, sampled away from the active edge
  always @(negedge i_clk) begin
    if (o_memory_read_strobe_n === 1'b0) rd_cnt++;
    if (o_port_read_strobe_n === 1'b0) prd_cnt++;
    if (o_early_port_write_strobe_n === 1'b0) epw_cnt++;
    if (o_memory_write_strobe_n === 1'b0) mw_cnt++;
    if (o_write_strobe_n === 1'b0) begin
      wr_cnt++;
      wr_data = o_data;
    end
    if (!o_port_read_strobe_n || !o_early_port_write_strobe_n || !o_memory_write_strobe_n) begin
      io_addr = {o_high_address_byte, o_low_address_byte};
    end
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // One request, held until taken, then waits for the given number of done pulses
  task automatic req(input cbcs_kind_t k, input logic [15:0] a, input logic [7:0] d, input int nd);
    @(posedge i_clk);
    {rd_cnt, prd_cnt, epw_cnt, wr_cnt, mw_cnt} = '0;
    i_req_valid <= 1'b1;
    i_req_kind <= k;
    i_req_addr <= a;
    i_req_wdata <= d;
    do @(negedge i_clk); while (o_req_accept !== 1'b1);
    @(posedge i_clk) i_req_valid <= 1'b0;
    repeat (nd) do @(negedge i_clk); while (o_done !== 1'b1);
  endtask

  task automatic t_port;
    req(CBCS_K_FETCH, 16'h0000, 8'h00, 1);
    chk(o_rdata, 8'hA5);
    chk(rd_cnt, 8);
    chk(o_pc, 16'h0001);
    req(CBCS_K_PORTIN, 16'h0000, 8'h00, 2);
    chk(io_addr, 16'hA4A4);
    chk(o_rdata, 8'hA5);
    chk(prd_cnt, 8);
    chk(o_pc, 16'h0002);
    req(CBCS_K_PORTOUT, 16'h0000, 8'h5C, 2);
    repeat (4) @(negedge i_clk);
    chk(io_addr, 16'hA7A7);
    chk(wr_data, 8'h5C);
    chk(wr_cnt, 6);
    chk(epw_cnt, 8);
    $display("port transfer test done");
  endtask

  task automatic t_write_wait;
    req(CBCS_K_MEMWR, 16'h1234, 8'h3C, 1);
    repeat (4) @(negedge i_clk);
    chk(wr_data, 8'h3C);
    chk(wr_cnt, 6);
    chk(mw_cnt, 6);
    chk(io_addr, 16'h1234);
    @(posedge i_clk) wait_clks <= 8'd14;
    req(CBCS_K_FETCH, 16'h0000, 8'h00, 1);
    chk(o_rdata, 8'hA6);
    chk(rd_cnt > 8 && rd_cnt % 4 == 0, 1);
    @(posedge i_clk) wait_clks <= 8'd0;
    i_bus_output_enable_n <= 1'b1;
    repeat (4) @(negedge i_clk);
    chk({o_strobe_oe_n, o_data_oe_n}, 2'b11);
    @(posedge i_clk) i_bus_output_enable_n <= 1'b0;
    @(posedge i_clk) i_hold_request <= 1'b1;
    while (o_hold_acknowledge !== 1'b1) @(negedge i_clk);
    chk({o_address_oe_n, o_data_oe_n}, 2'b11);
    @(posedge i_clk) i_hold_request <= 1'b0;
    while (o_hold_acknowledge !== 1'b0) @(negedge i_clk);
    chk(o_address_oe_n, 0);
    $display("write and wait test done");
  endtask

  task automatic t_halt;
    req(CBCS_K_HALT, 16'h0000, 8'h00, 0);
    while (o_halted !== 1'b1) @(negedge i_clk);
    @(posedge i_clk) i_interrupt_request <= 1'b1;
    repeat (40) @(negedge i_clk);
    chk(o_halted, 1);
    @(posedge i_clk) i_hold_request <= 1'b1;
    while (o_hold_acknowledge !== 1'b1) @(negedge i_clk);
    chk(o_halted, 0);
    @(posedge i_clk) i_hold_request <= 1'b0;
    while (o_halted !== 1'b1) @(negedge i_clk);
    chk(o_hold_acknowledge, 0);
    @(posedge i_clk) i_interrupt_enable_flag <= 1'b1;
    // Acknowledge cycle starts from halt by itself, no request needed
    while (o_done !== 1'b1) @(negedge i_clk);
    chk(o_rdata, 8'hFF);
    chk(o_pc, 16'h0004);
    req(CBCS_K_FETCH, 16'h0000, 8'h00, 1);
    chk(o_pc, 16'h0038);
    @(posedge i_clk) {i_interrupt_request, i_interrupt_enable_flag} <= 2'b00;
    $display("halt and interrupt test done");
  endtask

  task automatic t_reset;
    req(CBCS_K_HALT, 16'h0000, 8'h00, 0);
    while (o_halted !== 1'b1) @(negedge i_clk);
    @(posedge i_clk) i_reset_request_in_n <= 1'b0;
    repeat (6) @(negedge i_clk);
    chk(o_status_strobe_n, 0);
    chk(o_pc, 16'h0000);
    chk(o_halted, 0);
    @(posedge i_clk) i_reset_request_in_n <= 1'b1;
    req(CBCS_K_FETCH, 16'h0000, 8'h00, 1);
    chk(o_rdata, 8'hA5);
    chk(o_pc, 16'h0001);
    $display("reset test done");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    {i_arst_n, i_req_valid, i_hold_request, i_interrupt_request} = '0;
    {i_interrupt_enable_flag, i_bus_output_enable_n} = '0;
    i_reset_request_in_n = 1'b1;
    i_req_last = 1'b1;
    i_req_states = 3'h3;
    i_req_kind = CBCS_K_FETCH;
    i_req_addr = 16'h0000;
    i_req_wdata = 8'h00;
    wait_clks = 8'd0;
    {err_total, checks_done, cyc} = '0;
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_port();
    t_write_wait();
    t_halt();
    t_reset();
    end_sim();
  end
endmodule
